// >>> src/flash_pkg.sv
// Shared constants and types for the flash controller and its requester
package flash_pkg;
  localparam int FLASH_BYTES = 8192;
  localparam int PAGE_BYTES = 512;
  localparam int ROW_BYTES = 64;
  localparam int ROWS_PER_PAGE = PAGE_BYTES / ROW_BYTES;
  localparam int SECTOR_BYTES = (FLASH_BYTES == 8192) ? 1024 : 512;
  localparam int NUM_PAGES = FLASH_BYTES / PAGE_BYTES;
  localparam int NUM_SECTORS = FLASH_BYTES / SECTOR_BYTES;
  localparam int OPTION_BYTES = 2;
  localparam logic [15:0] INFO_BASE = 16'hfe00;
  localparam logic [15:0] INFO_LAST = 16'hffff;
  localparam logic [15:0] FLASH_LIMIT = 16'(FLASH_BYTES);
  localparam logic [7:0] INFO_FILL = 8'hff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam int READ_PROTECT_BIT = 7;
  localparam logic [7:0] KEY_FIRST = 8'h73;
  localparam logic [7:0] KEY_SECOND = 8'h8c;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h63;
  localparam logic [7:0] CMD_PROTECT_SEL = 8'h5e;
  localparam logic [7:0] PROTECT_RESET = 8'h00;
  localparam logic [15:0] KHZ_RESET = 16'h0000;
  localparam int KHZ_DIVISOR = 1000;
  localparam int MIN_CLOCK_HZ = 32768;
  localparam int MAX_CLOCK_HZ = 20000000;
  localparam logic [15:0] MIN_KHZ = 16'(MIN_CLOCK_HZ / KHZ_DIVISOR);
  localparam logic [15:0] MAX_KHZ = 16'(MAX_CLOCK_HZ / KHZ_DIVISOR);
  localparam int PROG_TIME_US = 40;
  localparam int ERASE_TIME_US = 10000;
  localparam int US_PER_MS = 1000;

  typedef enum logic [2:0] {
    OP_CTRL = 3'b000,
    OP_PAGE = 3'b001,
    OP_FREQ_HI = 3'b010,
    OP_FREQ_LO = 3'b011,
    OP_PROG = 3'b100,
    OP_READ = 3'b101
  } op_e;

  typedef enum logic [2:0] {
    LK_LOCKED = 3'b000,
    LK_PAGE = 3'b001,
    LK_KEY1 = 3'b010,
    LK_KEY2 = 3'b011,
    LK_OPEN = 3'b100
  } lock_e;

  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00,
    RUN_PROG = 2'b01,
    RUN_ERASE = 2'b10,
    RUN_WAIT = 2'b11
  } run_e;
endpackage : flash_pkg

// >>> src/flash_if.sv
// Link between flash requester and flash controller
`timescale 1ns/1ps
interface flash_if (
  input logic clock,
  input logic rst
);
  logic req;
  flash_pkg::op_e op;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic debug;
  logic busy;
  logic ack;
  logic ack_err;
  logic [7:0] rdata;

  modport dev (
    input clock,
    input rst,
    input req,
    input op,
    input addr,
    input wdata,
    input debug,
    output busy,
    output ack,
    output ack_err,
    output rdata
  );

  modport req_end (
    input clock,
    input rst,
    output req,
    output op,
    output addr,
    output wdata,
    output debug,
    input busy,
    input ack,
    input ack_err,
    input rdata
  );
endinterface : flash_if

// >>> src/flash_program_erase_control.sv
// Flash array with its program and erase controller
// Functional notes
// [R1] 512-byte pages, smallest erasable unit
// [R2] Each page is 8 rows of 64 bytes
// [R3] Sectors 1024 bytes on largest, else 512
// [R4] Array size per variant, addresses from zero
// [R5] First two bytes hold option bits
// [R6] Info area FE00-FFFF readable, never written
// [R7] Controller times byte program, page and mass erase
// [R8] Protection by page, sector and whole memory
// [R9] Requests come from user code or debugger
// [R10] Requester loads both frequency bytes first
// [R11] Frequency bytes form kHz value, high first
// [R12] Operate only between 32768 Hz and 20 MHz
// [R13] Read protect hides flash from debugger
// [R14] Locked at reset until unlock completes
// [R15] Page, 73H, 8CH, same page unlocks
// [R16] 95H erases unlocked unprotected page, else relock
// [R17] 5EH selects set-only sector protect register
// [R18] Pulse lengths counted from kHz value
`timescale 1ns/1ps
module flash_program_erase_control #(
  parameter int erase_time_us = flash_pkg::ERASE_TIME_US
) (
  flash_if.dev link,
  output logic read_protect_option
);
  localparam int PAGE_W = $clog2(flash_pkg::NUM_PAGES);
  localparam int SECT_W = $clog2(flash_pkg::NUM_SECTORS);
  localparam int ADDR_W = $clog2(flash_pkg::FLASH_BYTES);
  localparam int PAGE_SHIFT = $clog2(flash_pkg::PAGE_BYTES);
  localparam int SECT_SHIFT = $clog2(flash_pkg::SECTOR_BYTES);

  typedef struct packed {
    flash_pkg::run_e run;
    flash_pkg::lock_e lock;
    logic [7:0] page;
    logic prot_sel;
    logic [7:0] prot;
    logic [15:0] khz;
    logic [23:0] timer;
    logic sweeping;
    logic [ADDR_W-1:0] sweep;
    logic [ADDR_W-1:0] sweep_end;
    logic busy;
    logic ack;
    logic ack_err;
    logic [7:0] rdata;
    logic rp;
  } state_s;

  state_s s_reg;
  state_s s_next;
  logic [7:0] mem [flash_pkg::FLASH_BYTES];
  logic mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic in_array;
  logic in_info;
  logic [ADDR_W-1:0] a;
  logic [PAGE_W-1:0] addr_page;
  logic [PAGE_W-1:0] act_page;
  logic [SECT_W-1:0] addr_sect;
  logic [SECT_W-1:0] act_sect;
  logic freq_ok;
  logic [23:0] prog_cycles;
  logic [23:0] erase_cycles;

  assign link.busy = s_reg.busy;
  assign link.ack = s_reg.ack;
  assign link.ack_err = s_reg.ack_err;
  assign link.rdata = s_reg.rdata;
  assign read_protect_option = s_reg.rp;

  always_comb begin
    a = link.addr[ADDR_W-1:0];
    in_array = link.addr < flash_pkg::FLASH_LIMIT; // [R4]
    in_info = link.addr >= flash_pkg::INFO_BASE && link.addr <= flash_pkg::INFO_LAST; // [R6]
    addr_page = a[ADDR_W-1:PAGE_SHIFT]; // [R1]
    act_page = s_reg.page[PAGE_W-1:0];
    addr_sect = a[ADDR_W-1:SECT_SHIFT]; // [R3]
    act_sect = SECT_W'({act_page, {PAGE_SHIFT{1'b0}}} >> SECT_SHIFT);
    freq_ok = s_reg.khz >= flash_pkg::MIN_KHZ && s_reg.khz <= flash_pkg::MAX_KHZ; // [R12]
    prog_cycles = 24'(({16'h0000, s_reg.khz} * 32'(flash_pkg::PROG_TIME_US))
                      / 32'(flash_pkg::KHZ_DIVISOR)); // [R18]
    erase_cycles = 24'(({16'h0000, s_reg.khz} * 32'(erase_time_us))
                       / 32'(flash_pkg::KHZ_DIVISOR)); // [R18]
  end

  always_comb begin
    s_next = s_reg;
    s_next.ack = 1'b0;
    s_next.ack_err = 1'b0;
    s_next.rp = mem[0][flash_pkg::READ_PROTECT_BIT] == 1'b0; // [R5]
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = flash_pkg::ERASED_BYTE;
    case (s_reg.run)
      flash_pkg::RUN_IDLE: begin
        if (link.req) begin // [R9]
          s_next.ack = 1'b1;
          case (link.op)
            flash_pkg::OP_CTRL: begin
              s_next.prot_sel = link.wdata == flash_pkg::CMD_PROTECT_SEL; // [R17]
              s_next.lock = flash_pkg::LK_LOCKED; // [R16]
              if (s_reg.lock == flash_pkg::LK_OPEN && link.wdata == flash_pkg::CMD_PAGE_ERASE) begin
                if (freq_ok && (link.debug || !s_reg.prot[act_sect])) begin // [R8] [R16]
                  s_next.run = flash_pkg::RUN_ERASE; // [R7]
                  s_next.sweeping = 1'b1;
                  s_next.sweep = ADDR_W'({act_page, {PAGE_SHIFT{1'b0}}}); // [R1]
                  s_next.sweep_end = ADDR_W'({act_page, {PAGE_SHIFT{1'b0}}})
                    + ADDR_W'(flash_pkg::ROWS_PER_PAGE * flash_pkg::ROW_BYTES - 1); // [R2]
                  s_next.timer = erase_cycles;
                  s_next.busy = 1'b1;
                  s_next.ack = 1'b0;
                end else begin
                  s_next.ack_err = 1'b1;
                end
              end else if (s_reg.lock == flash_pkg::LK_OPEN
                           && link.wdata == flash_pkg::CMD_MASS_ERASE) begin
                if (freq_ok && link.debug) begin // [R8]
                  s_next.run = flash_pkg::RUN_ERASE; // [R7]
                  s_next.sweeping = 1'b1;
                  s_next.sweep = '0;
                  s_next.sweep_end = '1;
                  s_next.timer = erase_cycles;
                  s_next.busy = 1'b1;
                  s_next.ack = 1'b0;
                end else begin
                  s_next.ack_err = 1'b1;
                end
              end else if (s_reg.lock == flash_pkg::LK_PAGE
                           && link.wdata == flash_pkg::KEY_FIRST) begin
                s_next.lock = flash_pkg::LK_KEY1; // [R15]
              end else if (s_reg.lock == flash_pkg::LK_KEY1
                           && link.wdata == flash_pkg::KEY_SECOND) begin
                s_next.lock = flash_pkg::LK_KEY2; // [R15]
              end
            end
            flash_pkg::OP_PAGE: begin
              if (s_reg.prot_sel) begin
                s_next.prot = s_reg.prot | link.wdata; // [R17]
              end else begin
                s_next.page = link.wdata;
                if (s_reg.lock == flash_pkg::LK_KEY2) begin
                  s_next.lock = (link.wdata == s_reg.page
                                 && link.wdata < 8'(flash_pkg::NUM_PAGES))
                                ? flash_pkg::LK_OPEN : flash_pkg::LK_LOCKED; // [R15]
                end else begin
                  s_next.lock = flash_pkg::LK_PAGE; // [R14]
                end
              end
            end
            flash_pkg::OP_FREQ_HI: s_next.khz[15:8] = link.wdata; // [R11]
            flash_pkg::OP_FREQ_LO: s_next.khz[7:0] = link.wdata; // [R11]
            flash_pkg::OP_PROG: begin
              if (s_reg.lock == flash_pkg::LK_OPEN && in_array && freq_ok
                  && addr_page == act_page
                  && (link.debug || !s_reg.prot[addr_sect])) begin // [R6] [R8] [R14]
                mem_we = 1'b1;
                mem_wa = a;
                mem_wd = mem[a] & link.wdata;
                s_next.run = flash_pkg::RUN_PROG; // [R7]
                s_next.timer = prog_cycles;
                s_next.busy = 1'b1;
                s_next.ack = 1'b0;
              end else begin
                s_next.ack_err = 1'b1;
              end
            end
            flash_pkg::OP_READ: begin
              s_next.rdata = 8'h00;
              if (in_array) begin
                if (link.debug && s_reg.rp) begin
                  s_next.ack_err = 1'b1; // [R13]
                end else begin
                  s_next.rdata = mem[a];
                end
              end else if (in_info) begin
                s_next.rdata = flash_pkg::INFO_FILL; // [R6]
              end else begin
                s_next.ack_err = 1'b1;
              end
            end
            default: s_next.ack_err = 1'b1;
          endcase
        end
      end
      flash_pkg::RUN_PROG: begin
        if (s_reg.timer <= 24'h000001) begin // [R18]
          s_next.run = flash_pkg::RUN_IDLE;
          s_next.busy = 1'b0;
          s_next.ack = 1'b1;
        end else begin
          s_next.timer = s_reg.timer - 24'h000001;
        end
      end
      flash_pkg::RUN_ERASE: begin
        if (s_reg.sweeping) begin
          mem_we = 1'b1; // [R7]
          mem_wa = s_reg.sweep;
          s_next.sweep = s_reg.sweep + ADDR_W'(1);
          s_next.sweeping = s_reg.sweep != s_reg.sweep_end;
        end
        if (s_reg.timer > 24'h000001) begin
          s_next.timer = s_reg.timer - 24'h000001;
        end else if (!s_reg.sweeping) begin // [R18]
          s_next.run = flash_pkg::RUN_IDLE;
          s_next.busy = 1'b0;
          s_next.ack = 1'b1;
          s_next.lock = flash_pkg::LK_LOCKED;
        end
      end
      default: begin
        s_next.run = flash_pkg::RUN_IDLE;
        s_next.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge link.clock) begin
    if (link.rst) begin
      s_reg.run <= flash_pkg::RUN_IDLE;
      s_reg.lock <= flash_pkg::LK_LOCKED; // [R14]
      s_reg.page <= 8'h00;
      s_reg.prot_sel <= 1'b0;
      s_reg.prot <= flash_pkg::PROTECT_RESET; // [R17]
      s_reg.khz <= flash_pkg::KHZ_RESET;
      s_reg.timer <= 24'h000000;
      s_reg.sweeping <= 1'b0;
      s_reg.sweep <= '0;
      s_reg.sweep_end <= '0;
      s_reg.busy <= 1'b0;
      s_reg.ack <= 1'b0;
      s_reg.ack_err <= 1'b0;
      s_reg.rdata <= 8'h00;
      s_reg.rp <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge link.clock) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end
endmodule : flash_program_erase_control

// >>> src/flash_requester.sv
// Requester end: forwards user commands to the flash controller
`timescale 1ns/1ps
module flash_requester (
  flash_if.req_end link,
  input wire logic cmd_valid,
  input wire flash_pkg::op_e cmd_op,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_debug,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic rsp_err,
  output logic [7:0] rsp_data
);
  typedef struct packed {
    logic waiting;
    logic hi_loaded;
    logic lo_loaded;
    logic [15:0] khz;
    logic req;
    flash_pkg::op_e op;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic debug;
    logic ready;
    logic rsp_valid;
    logic rsp_err;
    logic [7:0] rsp_data;
  } state_s;

  state_s s_reg;
  state_s s_next;
  logic needs_freq;
  logic freq_ready;

  assign link.req = s_reg.req;
  assign link.op = s_reg.op;
  assign link.addr = s_reg.addr;
  assign link.wdata = s_reg.wdata;
  assign link.debug = s_reg.debug;
  assign cmd_ready = s_reg.ready;
  assign rsp_valid = s_reg.rsp_valid;
  assign rsp_err = s_reg.rsp_err;
  assign rsp_data = s_reg.rsp_data;

  always_comb begin
    needs_freq = cmd_op == flash_pkg::OP_PROG
                 || (cmd_op == flash_pkg::OP_CTRL
                     && (cmd_data == flash_pkg::CMD_PAGE_ERASE
                         || cmd_data == flash_pkg::CMD_MASS_ERASE));
    freq_ready = s_reg.hi_loaded && s_reg.lo_loaded
                 && s_reg.khz >= flash_pkg::MIN_KHZ && s_reg.khz <= flash_pkg::MAX_KHZ; // [R10] [R12]
    s_next = s_reg;
    s_next.req = 1'b0;
    s_next.rsp_valid = 1'b0;
    if (!s_reg.waiting) begin
      if (cmd_valid && s_reg.ready) begin
        s_next.ready = 1'b0;
        if (needs_freq && !freq_ready) begin
          s_next.rsp_valid = 1'b1; // [R10]
          s_next.rsp_err = 1'b1;
          s_next.rsp_data = 8'h00;
        end else begin
          s_next.waiting = 1'b1; // [R9]
          s_next.req = 1'b1;
          s_next.op = cmd_op;
          s_next.addr = cmd_addr;
          s_next.wdata = cmd_data;
          s_next.debug = cmd_debug;
          if (cmd_op == flash_pkg::OP_FREQ_HI) begin
            s_next.hi_loaded = 1'b1;
            s_next.khz[15:8] = cmd_data; // [R11]
          end
          if (cmd_op == flash_pkg::OP_FREQ_LO) begin
            s_next.lo_loaded = 1'b1;
            s_next.khz[7:0] = cmd_data; // [R11]
          end
        end
      end else begin
        s_next.ready = 1'b1;
      end
    end else if (link.ack) begin
      s_next.waiting = 1'b0;
      s_next.rsp_valid = 1'b1;
      s_next.rsp_err = link.ack_err;
      s_next.rsp_data = link.rdata;
    end
  end

  always_ff @(posedge link.clock) begin
    if (link.rst) begin
      s_reg.waiting <= 1'b0;
      s_reg.hi_loaded <= 1'b0;
      s_reg.lo_loaded <= 1'b0;
      s_reg.khz <= flash_pkg::KHZ_RESET;
      s_reg.req <= 1'b0;
      s_reg.op <= flash_pkg::OP_CTRL;
      s_reg.addr <= 16'h0000;
      s_reg.wdata <= 8'h00;
      s_reg.debug <= 1'b0;
      s_reg.ready <= 1'b0;
      s_reg.rsp_valid <= 1'b0;
      s_reg.rsp_err <= 1'b0;
      s_reg.rsp_data <= 8'h00;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : flash_requester

// >>> tb/flash_asserts.sv
// Checker for the link between requester and flash controller
`timescale 1ns/1ps
module flash_asserts (
  input logic clock,
  input logic rst,
  input logic req,
  input flash_pkg::op_e op,
  input logic [15:0] addr,
  input logic [7:0] wdata,
  input logic debug,
  input logic busy,
  input logic ack,
  input logic ack_err,
  input logic [7:0] rdata,
  input logic read_protect_option
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic rd;
  logic pr;
  logic slow;
  assign rd = req && op == flash_pkg::OP_READ;
  assign pr = req && op == flash_pkg::OP_PROG;
  assign slow = op == flash_pkg::OP_CTRL
                && (wdata == flash_pkg::CMD_PAGE_ERASE || wdata == flash_pkg::CMD_MASS_ERASE);
  a_err_with_ack: assert property (ack_err |-> ack)
    else $error("ack_err without ack");
  a_reset_idle: assert property ($fell(rst) |-> !busy && !ack && rdata == 8'h00)
    else $error("outputs not idle after reset");
  a_quick_answer: assert property (req && !busy && !pr && !slow |=> ack)
    else $error("request not answered next cycle");
  a_info_read: assert property (rd && !debug && addr >= flash_pkg::INFO_BASE |=>
    ack && !ack_err && rdata == flash_pkg::INFO_FILL) else $error("info read wrong");
  a_info_no_write: assert property (pr && addr >= flash_pkg::INFO_BASE |=> ack && ack_err)
    else $error("info area write not refused");
  a_prog_timed: assert property (pr |=> ##[0:800] ack)
    else $error("program did not finish in time");
  a_busy_ends_ack: assert property ($fell(busy) |-> ack)
    else $error("busy fell without ack");
  a_debug_hidden: assert property (rd && debug && read_protect_option &&
    addr < flash_pkg::FLASH_LIMIT |=> ack_err && rdata == 8'h00)
    else $error("protected flash read by debugger");
  a_no_req_busy: assert property (busy |-> !req)
    else $error("request while busy");
  c_mass: cover property (req && op == flash_pkg::OP_CTRL
    && wdata == flash_pkg::CMD_MASS_ERASE && debug);
  c_prog: cover property ($fell(busy) && !ack_err);
  c_hidden: cover property (rd && debug && read_protect_option);
endmodule : flash_asserts

// >>> tb/flash_program_erase_control_bench.sv
// Bench joining requester and flash controller
`timescale 1ns/1ps
`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin fails++; \
  $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp); end end
module flash_program_erase_control_bench;
  localparam flash_pkg::op_e rd = flash_pkg::OP_READ;
  localparam flash_pkg::op_e pr = flash_pkg::OP_PROG;
  localparam flash_pkg::op_e ct = flash_pkg::OP_CTRL;
  localparam flash_pkg::op_e pg = flash_pkg::OP_PAGE;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  flash_pkg::op_e cmd_op = flash_pkg::OP_READ;
  logic [15:0] cmd_addr = 16'h0000;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_debug = 1'b0;
  logic cmd_ready;
  logic rsp_valid;
  logic rsp_err;
  logic rpo;
  logic [7:0] rsp_data;
  int fails = 0;
  int compares = 0;
  int busy_total = 0;
  always #2 clock = ~clock;
  flash_if link (.clock(clock), .rst(rst));
  always @(posedge clock) if (link.busy === 1'b1) busy_total <= busy_total + 1;
  flash_program_erase_control #(.erase_time_us(2)) i_flash_program_erase_control (
    .link(link), .read_protect_option(rpo));
  flash_requester i_flash_requester (.link(link), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_debug(cmd_debug), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_data(rsp_data));
  flash_asserts i_flash_asserts (.clock(link.clock), .rst(link.rst), .req(link.req),
    .op(link.op), .addr(link.addr), .wdata(link.wdata), .debug(link.debug),
    .busy(link.busy), .ack(link.ack), .ack_err(link.ack_err), .rdata(link.rdata),
    .read_protect_option(rpo));
  task automatic step;
    @(posedge clock);
    #1;
  endtask : step
  // Offer one command and wait for its response
  task automatic run(input flash_pkg::op_e o, input logic [15:0] a, input logic [7:0] d,
    input logic dbg, input logic e);
    int n;
    n = 0;
    cmd_op = o;
    cmd_addr = a;
    cmd_data = d;
    cmd_debug = dbg;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 100) begin
      step();
      n++;
    end
    if (n >= 100) begin
      fails++;
      $display("[ERR] %0t command not taken", $time);
    end
    step();
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20000) begin
      step();
      n++;
    end
    if (n >= 20000) begin
      fails++;
      $display("[ERR] %0t no response", $time);
    end
    `CHECK(rsp_err, e);
    // Let an edge pass so the next command never drives in this time step
    step();
  endtask : run
  task automatic freq(input logic [15:0] khz);
    run(flash_pkg::OP_FREQ_HI, 16'h0000, khz[15:8], 1'b0, 1'b0);
    run(flash_pkg::OP_FREQ_LO, 16'h0000, khz[7:0], 1'b0, 1'b0);
  endtask : freq
  task automatic unlock(input logic [7:0] p1, input logic [7:0] p2);
    run(pg, 16'h0000, p1, 1'b0, 1'b0);
    run(ct, 16'h0000, flash_pkg::KEY_FIRST, 1'b0, 1'b0);
    run(ct, 16'h0000, flash_pkg::KEY_SECOND, 1'b0, 1'b0);
    run(pg, 16'h0000, p2, 1'b0, 1'b0);
  endtask : unlock
  task automatic t_freq;
    run(pr, 16'h0200, 8'h00, 1'b0, 1'b1);
    freq(16'h0010);
    run(pr, 16'h0200, 8'h00, 1'b0, 1'b1);
    freq(16'h03e8);
  endtask : t_freq
  task automatic t_lock;
    run(pr, 16'h0100, 8'h00, 1'b0, 1'b1);
    unlock(8'h00, 8'h01);
    run(pr, 16'h0000, 8'h00, 1'b0, 1'b1);
    run(pr, 16'h0200, 8'h00, 1'b0, 1'b1);
  endtask : t_lock
  task automatic t_mass;
    unlock(8'h00, 8'h00);
    run(ct, 16'h0000, flash_pkg::CMD_MASS_ERASE, 1'b0, 1'b1);
    unlock(8'h00, 8'h00);
    run(ct, 16'h0000, flash_pkg::CMD_MASS_ERASE, 1'b1, 1'b0);
    run(rd, 16'h0000, 8'h00, 1'b0, 1'b0);
    `CHECK(rsp_data, flash_pkg::ERASED_BYTE);
    run(rd, 16'h1fff, 8'h00, 1'b0, 1'b0);
    `CHECK(rsp_data, flash_pkg::ERASED_BYTE);
    run(rd, 16'h2000, 8'h00, 1'b0, 1'b1);
    `CHECK(rpo, 1'b0);
  endtask : t_mass
  task automatic t_prog;
    int b;
    unlock(8'h01, 8'h01);
    b = busy_total;
    run(pr, 16'h0205, 8'h5a, 1'b0, 1'b0);
    `CHECK(busy_total - b, 16'h03e8 * flash_pkg::PROG_TIME_US / flash_pkg::KHZ_DIVISOR);
    run(pr, 16'h0205, 8'hf0, 1'b0, 1'b0);
    run(pr, 16'h03ff, 8'h0f, 1'b0, 1'b0);
    run(pr, 16'h0400, 8'h00, 1'b0, 1'b1);
    run(rd, 16'h0205, 8'h00, 1'b0, 1'b0);
    `CHECK(rsp_data, 8'h50);
  endtask : t_prog
  task automatic t_info;
    run(rd, 16'hfe00, 8'h00, 1'b0, 1'b0);
    `CHECK(rsp_data, flash_pkg::INFO_FILL);
    run(rd, 16'hffff, 8'h00, 1'b0, 1'b0);
    `CHECK(rsp_data, flash_pkg::INFO_FILL);
    run(pr, 16'hfe00, 8'h00, 1'b0, 1'b1);
  endtask : t_info
  task automatic t_erase;
    unlock(8'h01, 8'h01);
    run(ct, 16'h0000, 8'h11, 1'b0, 1'b0);
    run(pr, 16'h0206, 8'h00, 1'b0, 1'b1);
    unlock(8'h01, 8'h01);
    run(ct, 16'h0000, flash_pkg::CMD_PAGE_ERASE, 1'b0, 1'b0);
    run(rd, 16'h0205, 8'h00, 1'b0, 1'b0);
    `CHECK(rsp_data, flash_pkg::ERASED_BYTE);
    run(rd, 16'h03ff, 8'h00, 1'b0, 1'b0);
    `CHECK(rsp_data, flash_pkg::ERASED_BYTE);
    run(pr, 16'h0206, 8'h00, 1'b0, 1'b1);
  endtask : t_erase
  task automatic t_protect;
    run(ct, 16'h0000, flash_pkg::CMD_PROTECT_SEL, 1'b0, 1'b0);
    run(pg, 16'h0000, 8'h02, 1'b0, 1'b0);
    run(pg, 16'h0000, 8'h00, 1'b0, 1'b0);
    run(ct, 16'h0000, 8'h00, 1'b0, 1'b0);
    unlock(8'h02, 8'h02);
    run(pr, 16'h0401, 8'h11, 1'b1, 1'b0);
    run(pr, 16'h0402, 8'h00, 1'b0, 1'b1);
    run(ct, 16'h0000, flash_pkg::CMD_PAGE_ERASE, 1'b0, 1'b1);
  endtask : t_protect
  task automatic t_rprot;
    unlock(8'h00, 8'h00);
    run(pr, 16'h0000, 8'h7f, 1'b1, 1'b0);
    `CHECK(rpo, 1'b1);
    run(rd, 16'h0205, 8'h00, 1'b1, 1'b1);
    run(rd, 16'h0205, 8'h00, 1'b0, 1'b0);
    `CHECK(rsp_data, flash_pkg::ERASED_BYTE);
  endtask : t_rprot
  task automatic wrap_up;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (60000) @(posedge clock);
    fails++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge clock);
    #1;
    rst = 1'b0;
    step();
    t_freq();
    t_lock();
    t_mass();
    t_prog();
    t_info();
    t_erase();
    t_protect();
    t_rprot();
    wrap_up();
  end
endmodule : flash_program_erase_control_bench
